// ---- common/mabsc_pkg.sv ----
// Constants and helpers for the channel-B step 6/7 configuration registers
package mabsc_pkg;

  // Wishbone geometry
  localparam int ADR_W = 12;
  localparam int IDX_W = 10;

  // Register indices; byte address is four times the index
  localparam logic [IDX_W-1:0] IDX_STEP6 = 10'h0D6;
  localparam logic [IDX_W-1:0] IDX_STEP7 = 10'h0D7;

  // Reset values
  localparam logic [15:0] RST_STEP6 = 16'h0006;
  localparam logic [15:0] RST_STEP7 = 16'h0007;

  // Writable bits; reserved 12:5 read zero
  localparam logic [15:0] WR_MASK = 16'hE01F;

  // Field positions
  localparam int EN_BIT = 15;
  localparam int GAIN_HI = 14;
  localparam int GAIN_LO = 13;
  localparam int NEG_BIT = 4;
  localparam int POS_HI = 3;
  localparam int POS_LO = 0;

  // Gain codes and factors
  localparam logic [1:0] GAIN_CODE_X1 = 2'h0;
  localparam logic [1:0] GAIN_CODE_X2 = 2'h1;
  localparam logic [2:0] GAIN_X1 = 3'h1;
  localparam logic [2:0] GAIN_X2 = 3'h2;
  localparam logic [2:0] GAIN_X4 = 3'h4;

  // Slot codes from the address decode: {hit, step7}
  localparam logic [1:0] SLOT_NONE = 2'h0;
  localparam logic [1:0] SLOT_STEP6 = 2'h2;
  localparam logic [1:0] SLOT_STEP7 = 2'h3;

  // Gain code to factor
  function automatic logic [2:0] gain_factor(input logic [1:0] code);
    if (code == GAIN_CODE_X1) begin
      gain_factor = GAIN_X1;
    end else if (code == GAIN_CODE_X2) begin
      gain_factor = GAIN_X2;
    end else begin
      gain_factor = GAIN_X4;
    end
  endfunction

  // Address to slot
  function automatic logic [1:0] reg_slot(input logic [ADR_W-1:0] adr);
    logic [IDX_W-1:0] idx;
    idx = adr[ADR_W-1:2];
    if (idx == IDX_STEP6) begin
      reg_slot = SLOT_STEP6;
    end else if (idx == IDX_STEP7) begin
      reg_slot = SLOT_STEP7;
    end else begin
      reg_slot = SLOT_NONE;
    end
  endfunction

  // Byte-lane merge of a write, reserved bits forced to zero
  function automatic logic [15:0] lane_merge(input logic [15:0] old_val,
                                             input logic [15:0] wdata,
                                             input logic [1:0] sel);
    logic [15:0] merged;
    merged = old_val;
    if (sel[0]) begin
      merged[7:0] = wdata[7:0];
    end
    if (sel[1]) begin
      merged[15:8] = wdata[15:8];
    end
    lane_merge = merged & WR_MASK;
  endfunction

endpackage

// ---- dv/mux_adc_b_sequence_step_cfg_tb.sv ----
// Self-checking bench for the channel-B step 6/7 configuration registers
`timescale 1ns/100ps
`default_nettype none

module mux_adc_b_sequence_step_cfg_tb;
  logic mclk = 1'b0;
  logic srst = 1'b1;
  logic ce = 1'b1;
  logic cyc = 1'b0;
  logic stb = 1'b0;
  logic we = 1'b0;
  logic [11:0] adr = 12'h000;
  logic [3:0] sel = 4'h0;
  logic [31:0] dat = 32'h00000000;
  logic [31:0] dat_o, rdat;
  logic ack, en6, en7, pi6, pi7, ng6, ng7;
  logic [2:0] g6, g7;
  logic [3:0] p6, p7;
  logic [15:0] m [2];
  logic [31:0] rng = 32'h4C1C6A3C;
  int failures = 0;
  int cmp_count = 0;
  int cycles = 0;

  mabsc_step_regs dut_u (
    .mclk(mclk), .srst(srst), .ce(ce),
    .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel),
    .wb_dat_i(dat), .wb_dat_o(dat_o), .wb_ack_o(ack),
    .seq_b_step6_enable(en6), .seq_b_step6_gain(g6), .seq_b_step6_pos_select(p6),
    .seq_b_step6_pos_internal(pi6), .seq_b_step6_neg_select(ng6),
    .seq_b_step7_enable(en7), .seq_b_step7_gain(g7), .seq_b_step7_pos_select(p7),
    .seq_b_step7_pos_internal(pi7), .seq_b_step7_neg_select(ng7)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Clock, timeout, helpers
  always #4 mclk = ~mclk;

  always @(posedge mclk) begin
    cycles++;
    if (cycles == 5000) begin
      failures++;
      stop_test();
    end
  end

  function automatic logic [31:0] next_rnd();
    rng = rng ^ (rng << 13);
    rng = rng ^ (rng >> 17);
    rng = rng ^ (rng << 5);
    return rng;
  endfunction

  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    cmp_count++;
    if (g !== e) begin
      failures++;
      $display("mismatch %s expected %h seen %h", nm, e, g);
    end
  endtask

  // Expected step outputs from a register word
  function automatic logic [9:0] expo(input logic [15:0] v);
    logic [2:0] g;
    g = (v[14:13] == 2'h0) ? 3'h1 : (v[14:13] == 2'h1) ? 3'h2 : 3'h4;
    return {v[15], g, v[3:0], v[3], v[4] & ~v[3]};
  endfunction

  task automatic chk_out();
    @(posedge mclk);
    chk("step6 outputs", {22'h0, expo(m[0])},
        {22'h0, en6, g6, p6, pi6, ng6});
    chk("step7 outputs", {22'h0, expo(m[1])},
        {22'h0, en7, g7, p7, pi7, ng7});
  endtask

  // Classic Wishbone single cycle
  task automatic wb(input logic w, input logic [11:0] a, input logic [31:0] d,
                    input logic [3:0] s);
    int n;
    n = 0;
    @(posedge mclk);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    dat <= d;
    sel <= s;
    do begin
      @(posedge mclk);
      n++;
    end while (ack !== 1'b1);
    chk("ack latency", 32'h2, n);
    rdat = dat_o;
    cyc <= 1'b0;
    stb <= 1'b0;
  endtask

  // Write merge by byte lane, reserved bits dropped
  function automatic logic [15:0] mrg(input logic [15:0] v, input logic [31:0] d,
                                      input logic [3:0] s);
    logic [15:0] r;
    r = v;
    if (s[0]) r[7:0] = d[7:0];
    if (s[1]) r[15:8] = d[15:8];
    return r & 16'hE01F;
  endfunction

  task automatic access(input logic w, input logic [11:0] a, input logic [31:0] d,
                        input logic [3:0] s);
    int k;
    k = (a[11:2] == 10'h0D6) ? 0 : (a[11:2] == 10'h0D7) ? 1 : 2;
    wb(w, a, d, s);
    if (!w) begin
      chk("read data", (k < 2) ? {16'h0000, m[k]} : 32'h00000000,
          rdat);
    end
    if (w && k < 2) begin
      m[k] = mrg(m[k], d, s);
    end
  endtask

  // Request raised while the clock enable is low
  task automatic frozen_write(input logic [11:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge mclk);
    ce <= 1'b0;
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= 1'b1;
    adr <= a;
    dat <= d;
    sel <= 4'hF;
    repeat (3) @(posedge mclk);
    chk_out();
    chk("frozen ack", 32'h0, {31'h0, ack});
    ce <= 1'b1;
    do begin
      @(posedge mclk);
      n++;
    end while (ack !== 1'b1);
    chk("frozen ack latency", 32'h2, n);
    cyc <= 1'b0;
    stb <= 1'b0;
    m[a[2]] = mrg(m[a[2]], d, 4'hF);
  endtask

  task automatic do_reset();
    srst <= 1'b1;
    repeat (20) @(posedge mclk);
    srst <= 1'b0;
    m[0] = 16'h0006;
    m[1] = 16'h0007;
  endtask

  task automatic stop_test();
    if (failures == 0 && cmp_count > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask

  ////////////////////////////////////////////////////////////////////////////
  // Main sequence
  initial begin
    logic [31:0] d;
    logic [11:0] a;
    do_reset();
    chk_out();
    access(1'b0, 12'h358, next_rnd(), 4'hF);
    access(1'b0, 12'h35C, next_rnd(), 4'hF);
    // Every positive code with both negative settings on both steps
    for (int i = 0; i < 64; i++) begin
      d = next_rnd();
      d[4:0] = i[4:0];
      d[14:13] = i[1:0];
      a = i[5] ? 12'h35C : 12'h358;
      access(1'b1, a, d, 4'hF);
      chk_out();
      access(1'b0, a, next_rnd(), 4'hF);
    end
    // Byte-lane writes, low address bits varied
    for (int i = 0; i < 16; i++) begin
      a = {i[0] ? 10'h0D7 : 10'h0D6, i[2:1]};
      d = next_rnd();
      access(1'b1, a, d, d[19:16]);
      chk_out();
      access(1'b0, a, next_rnd(), 4'hF);
    end
    // Clock enable low holds the bus and the step outputs
    frozen_write(12'h358, next_rnd());
    chk_out();
    frozen_write(12'h35C, next_rnd());
    chk_out();
    // Unmapped places leave both steps alone
    access(1'b1, 12'h360, 32'hFFFFFFFF, 4'hF);
    access(1'b1, 12'h354, 32'hFFFFFFFF, 4'hF);
    access(1'b0, 12'h360, next_rnd(), 4'hF);
    access(1'b0, 12'h358, next_rnd(), 4'hF);
    access(1'b0, 12'h35C, next_rnd(), 4'hF);
    // Reset again in mid-run
    access(1'b1, 12'h358, 32'hFFFFFFFF, 4'hF);
    do_reset();
    chk_out();
    access(1'b0, 12'h358, next_rnd(), 4'hF);
    stop_test();
  end
endmodule

`default_nettype wire

// ---- src/mabsc_step_decode.sv ----
// Field decode of one sequence step configuration word
`timescale 1ns/100ps
`default_nettype none

module mabsc_step_decode (
  // Stored configuration
  input wire logic [15:0] cfg,
  // Decoded step controls
  output logic enable,
  output logic [2:0] gain_x,
  output logic [3:0] pos_select,
  output logic pos_internal,
  output logic neg_select
);

  // Step inclusion
  assign enable = cfg[mabsc_pkg::EN_BIT];

  // 00 gives 1, 01 gives 2, 10 and 11 give 4
  assign gain_x = mabsc_pkg::gain_factor(cfg[mabsc_pkg::GAIN_HI:mabsc_pkg::GAIN_LO]);

  // Codes 0..7 external inputs, 8..15 internal sources
  assign pos_select = cfg[mabsc_pkg::POS_HI:mabsc_pkg::POS_LO];
  assign pos_internal = cfg[mabsc_pkg::POS_HI];

  // Internal sources force the negative input, select bit ignored
  assign neg_select = pos_internal ? 1'b0 : cfg[mabsc_pkg::NEG_BIT];

endmodule

`default_nettype wire

// ---- src/mabsc_step_regs.sv ----
// Wishbone register bank for channel-B sequence steps 6 and 7
//
// Decided for this implementation: register access over Wishbone.
`timescale 1ns/100ps
`default_nettype none

////////////////////////////////////////////////////////////////////////////////
// Functional notes
// - Bit 15 of the step 6 word includes step 6 in the sequence when set; reset clear.
// - Gain bits 14:13 give gain 1 for 00, 2 for 01 and 4 for both 10 and 11.
// - Bit 4 routes analog ground (0) or external input seven (1) to the negative input.
// - Positive codes 0000 to 0111 route external inputs zero to seven in order.
// - Positive codes 1000 to 1111 route the eight internal sources, forcing the negative.
// - For an internal source code the negative select bit has no effect.
// - Step 6 resets with positive code 0110 and all other fields zero.
// - Step 7 sits at index D7h and resets to 0007h.
module mabsc_step_regs (
  // Clock, reset, enable
  input wire logic mclk,
  input wire logic srst,
  input wire logic ce,
  // Wishbone slave
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [mabsc_pkg::ADR_W-1:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  // Step 6 controls
  output logic seq_b_step6_enable,
  output logic [2:0] seq_b_step6_gain,
  output logic [3:0] seq_b_step6_pos_select,
  output logic seq_b_step6_pos_internal,
  output logic seq_b_step6_neg_select,
  // Step 7 controls
  output logic seq_b_step7_enable,
  output logic [2:0] seq_b_step7_gain,
  output logic [3:0] seq_b_step7_pos_select,
  output logic seq_b_step7_pos_internal,
  output logic seq_b_step7_neg_select
);

  ////////////////////////////////////////////////////////////////////////////////
  // Storage and decode

  logic [15:0] cfg_reg [0:1];
  logic req;
  logic [1:0] slot;
  logic [1:0] dec_en;
  logic [2:0] dec_gain [0:1];
  logic [3:0] dec_pos [0:1];
  logic [1:0] dec_int;
  logic [1:0] dec_neg;

  // New request not yet answered
  assign req = wb_cyc_i && wb_stb_i && !wb_ack_o;
  assign slot = mabsc_pkg::reg_slot(wb_adr_i);

  for (genvar s = 0; s < 2; s++) begin : g_step
    mabsc_step_decode u_dec (
      .cfg(cfg_reg[s]),
      .enable(dec_en[s]),
      .gain_x(dec_gain[s]),
      .pos_select(dec_pos[s]),
      .pos_internal(dec_int[s]),
      .neg_select(dec_neg[s])
    );
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Register writes

  always_ff @(posedge mclk) begin
    if (srst) begin
      cfg_reg[0] <= mabsc_pkg::RST_STEP6;
      cfg_reg[1] <= mabsc_pkg::RST_STEP7;
    end else if (ce && req && wb_we_i && slot[1]) begin
      cfg_reg[slot[0]] <= mabsc_pkg::lane_merge(cfg_reg[slot[0]], wb_dat_i[15:0],
                                                wb_sel_i[1:0]);
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Bus answer

  always_ff @(posedge mclk) begin
    if (srst) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h0000_0000;
    end else if (ce) begin
      wb_ack_o <= req;
      if (req && !wb_we_i && slot[1]) begin
        wb_dat_o <= {16'h0000, cfg_reg[slot[0]]};
      end else begin
        wb_dat_o <= 32'h0000_0000;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Step control outputs

  always_ff @(posedge mclk) begin
    if (srst) begin
      seq_b_step6_enable <= 1'b0;
      seq_b_step6_gain <= mabsc_pkg::GAIN_X1;
      seq_b_step6_pos_select <= mabsc_pkg::RST_STEP6[3:0];
      seq_b_step6_pos_internal <= 1'b0;
      seq_b_step6_neg_select <= 1'b0;
    end else if (ce) begin
      seq_b_step6_enable <= dec_en[0];
      seq_b_step6_gain <= dec_gain[0];
      seq_b_step6_pos_select <= dec_pos[0];
      seq_b_step6_pos_internal <= dec_int[0];
      seq_b_step6_neg_select <= dec_neg[0];
    end
  end

  always_ff @(posedge mclk) begin
    if (srst) begin
      seq_b_step7_enable <= 1'b0;
      seq_b_step7_gain <= mabsc_pkg::GAIN_X1;
      seq_b_step7_pos_select <= mabsc_pkg::RST_STEP7[3:0];
      seq_b_step7_pos_internal <= 1'b0;
      seq_b_step7_neg_select <= 1'b0;
    end else if (ce) begin
      seq_b_step7_enable <= dec_en[1];
      seq_b_step7_gain <= dec_gain[1];
      seq_b_step7_pos_select <= dec_pos[1];
      seq_b_step7_pos_internal <= dec_int[1];
      seq_b_step7_neg_select <= dec_neg[1];
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Checks

  default clocking cb @(posedge mclk);
  endclocking

  default disable iff (srst);

  ack_latency_a: assert property (ce && req |=> wb_ack_o)
    else $error("request not acknowledged next cycle");

  ack_single_a: assert property (wb_ack_o && ce |=> !wb_ack_o)
    else $error("ack held more than one cycle");

  step6_reset_a: assert property ($past(srst) |->
      cfg_reg[0] == mabsc_pkg::RST_STEP6 && seq_b_step6_pos_select == 4'h6
      && !seq_b_step6_enable && seq_b_step6_gain == 3'h1)
    else $error("step 6 reset value wrong");

  step7_reset_a: assert property ($past(srst) |->
      cfg_reg[1] == mabsc_pkg::RST_STEP7 && seq_b_step7_pos_select == 4'h7)
    else $error("step 7 reset value wrong");

  enable_write_a: assert property (
      (ce && req && wb_we_i && slot == mabsc_pkg::SLOT_STEP6 && wb_sel_i[1]) ##1 ce
      |=> seq_b_step6_enable == $past(wb_dat_i[15], 2))
    else $error("step 6 enable does not follow write");

  gain_map_a: assert property (ce |=>
      seq_b_step6_gain == (($past(cfg_reg[0][14:13]) == 2'h0) ? 3'h1 :
                           ($past(cfg_reg[0][14:13]) == 2'h1) ? 3'h2 : 3'h4))
    else $error("gain code mapped wrongly");

  neg_route_a: assert property (ce && !cfg_reg[1][3] |=>
      seq_b_step7_neg_select == $past(cfg_reg[1][4]))
    else $error("negative select not routed");

  pos_route_a: assert property (ce |=>
      seq_b_step7_pos_select == $past(cfg_reg[1][3:0]))
    else $error("positive select not routed");

  internal_src_a: assert property (
      seq_b_step6_pos_internal == (seq_b_step6_pos_select >= 4'h8))
    else $error("internal source flag wrong");

  neg_ignore_a: assert property (
      (seq_b_step7_pos_internal |-> !seq_b_step7_neg_select)
      and (seq_b_step6_pos_internal |-> !seq_b_step6_neg_select))
    else $error("negative select used with internal source");

  reserved_zero_a: assert property (wb_ack_o |-> wb_dat_o[31:16] == 16'h0000
      && wb_dat_o[12:5] == 8'h00)
    else $error("reserved bits read nonzero");

  unmapped_read_a: assert property (ce && req && !slot[1] |=> wb_dat_o == 32'h0)
    else $error("unmapped read not zero");

  unmapped_write_a: assert property (ce && req && wb_we_i && !slot[1] |=>
      cfg_reg[0] == $past(cfg_reg[0]) && cfg_reg[1] == $past(cfg_reg[1]))
    else $error("unmapped write changed a step");

  frozen_state_a: assert property (!ce |=> $stable(wb_ack_o) && $stable(wb_dat_o)
      && $stable(cfg_reg[0]) && $stable(cfg_reg[1]) && $stable(seq_b_step6_pos_select)
      && $stable(seq_b_step7_pos_select) && $stable(seq_b_step6_enable))
    else $error("state moved with clock enable low");

  step7_fields_a: assert property (ce |=>
      seq_b_step7_enable == $past(cfg_reg[1][mabsc_pkg::EN_BIT])
      && seq_b_step7_gain == (($past(cfg_reg[1][14:13]) == 2'h0) ? 3'h1 :
                              ($past(cfg_reg[1][14:13]) == 2'h1) ? 3'h2 : 3'h4))
    else $error("step 7 enable or gain wrong");

  lane_write_a: assert property (
      ce && req && wb_we_i && slot == mabsc_pkg::SLOT_STEP7 && wb_sel_i[0]
      |=> cfg_reg[1][4:0] == $past(wb_dat_i[4:0]) && cfg_reg[1][12:5] == 8'h00)
    else $error("step 7 low byte write wrong");

  reset_bus_a: assert property ($past(srst) |-> !wb_ack_o && wb_dat_o == 32'h0000_0000)
    else $error("bus answer not idle after reset");

  write_step6_c: cover property (ce && req && wb_we_i && slot == mabsc_pkg::SLOT_STEP6);

  read_step7_c: cover property (ce && req && !wb_we_i && slot == mabsc_pkg::SLOT_STEP7);

  internal_src_c: cover property (seq_b_step6_pos_internal && cfg_reg[0][4]);

  ext7_neg_c: cover property (seq_b_step7_neg_select && seq_b_step7_enable);

  frozen_req_c: cover property (!ce && req);

endmodule

`default_nettype wire
